// *** common/dcp_pkg.sv ***
// package: constants, enums and structs of the dma channel programming core
package dcp_pkg;
   localparam int DCP_DATA_W = 8;
   localparam int DCP_ADDR_W = 16;
   localparam int DCP_RR_NUM = 7;
   // command codes
   localparam logic [7:0] DCP_CMD_LOAD = 8'hCF;
   localparam logic [7:0] DCP_CMD_ENABLE = 8'h87;
   localparam logic [7:0] DCP_CMD_DISABLE = 8'h83;
   localparam logic [7:0] DCP_CMD_RD_MASK = 8'hBB;
   localparam logic [7:0] DCP_CMD_INIT_RD = 8'hA7;
   localparam logic [7:0] DCP_CMD_RD_STAT = 8'hBF;
   localparam logic [7:0] DCP_CMD_RESET = 8'hC3;
   // base byte field positions
   localparam int DCP_B_DIR = 2;
   localparam int DCP_B_TIM = 6;
   localparam int DCP_B_FIXED = 5;
   localparam int DCP_B_INC = 4;
   localparam int DCP_B_IO = 3;
   localparam int DCP_B_STOP = 2;
   localparam int DCP_B_AUTO = 5;
   localparam int DCP_B_WAIT = 4;
   localparam int DCP_B_RDYH = 3;
   localparam int DCP_B_PULSE = 3;
   localparam int DCP_B_VEC = 4;
   // status byte bit positions
   localparam int DCP_ST_XFER = 0;
   localparam int DCP_ST_RDY = 1;
   localparam int DCP_ST_MATCH = 4;
   localparam int DCP_ST_EOB = 5;
   // transfer modes
   localparam logic [1:0] DCP_MODE_BYTE = 2'h0;
   localparam logic [1:0] DCP_MODE_CONT = 2'h1;
   localparam logic [1:0] DCP_MODE_BURST = 2'h2;
   // reset values
   localparam logic [6:0] DCP_RD_MASK_RST = 7'h7F;
   localparam logic [15:0] DCP_WORD_RST = 16'h0000;

   typedef enum logic [2:0] {PH_IDLE, PH_REQ, PH_READ, PH_WRITE, PH_HOLD} dcp_phase_e;
   typedef enum logic [2:0] {
      GRP_NONE, GRP_XFER, GRP_PORT1, GRP_PORT2, GRP_MATCH, GRP_MODE, GRP_CTRL, GRP_CMD
   } dcp_group_e;

   // host strobes sampled at the pins
   typedef struct packed {
      logic ce_n;
      logic iorq_n;
      logic rd_n;
      logic wr_n;
   } dcp_host_s;

   // per-port addressing attributes
   typedef struct packed {
      logic fixed;
      logic inc;
      logic io;
   } dcp_port_s;

   // whole state of the core
   typedef struct packed {
      dcp_phase_e phase;
      logic enabled;
      dcp_group_e group;
      logic [4:0] ptr_mask;
      logic [1:0] xfer_op;
      logic dir_a2b;
      logic [15:0] blk_len;
      logic [15:0] a_start;
      logic [15:0] b_start;
      logic [15:0] a_cnt;
      logic [15:0] b_cnt;
      logic [15:0] byte_cnt;
      dcp_port_s a_port;
      dcp_port_s b_port;
      logic [7:0] cmp_mask;
      logic [7:0] match_byte;
      logic stop_on_match;
      logic [1:0] mode;
      logic auto_restart;
      logic wait_en;
      logic rdy_high;
      logic [6:0] rd_mask;
      logic [2:0] rd_ptr;
      logic rd_valid;
      logic hw_prev;
      logic hr_prev;
      logic [7:0] held_byte;
      logic [7:0] prev_byte;
      logic prev_valid;
      logic match_hit;
      logic eob;
      logic xfer_seen;
      logic [1:0] bai_hist;
      logic busreq_oe_n;
      logic [15:0] addr;
      logic rd_n;
      logic wr_n;
      logic iorq_n;
      logic mreq_n;
      logic bus_oe_n;
      logic [7:0] data;
      logic data_oe_n;
   } dcp_state_s;

   localparam dcp_state_s DCP_STATE_RST = '{
      phase: PH_IDLE, group: GRP_NONE, rd_mask: DCP_RD_MASK_RST, busreq_oe_n: 1'b1,
      addr: DCP_WORD_RST, rd_n: 1'b1, wr_n: 1'b1, iorq_n: 1'b1, mreq_n: 1'b1,
      bus_oe_n: 1'b1, data_oe_n: 1'b1, default: '0};
endpackage

// *** testbench/dcp_bus_partner.sv ***
// bus partner model: grants the buses and feeds read data
module dcp_bus_partner (
   input wire logic i_mclk,
   input wire logic i_busreq_n,
   output logic o_bai_n,
   output logic [7:0] o_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_bai_n = 1'b1;
   initial o_data = 8'h00;
   // acknowledge trails request; data changes every cycle
   always @(posedge i_mclk) begin
      o_bai_n <= #1 i_busreq_n;
      o_data <= #1 8'($urandom);
   end
endmodule // dcp_bus_partner

// *** testbench/tb_dma_channel_programming_core.sv ***
// self-checking bench of the dma channel programming core
module tb_dma_channel_programming_core;
   import dcp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, rdy = 0, bai_n, wr_q = 1, rd_q = 1;
   dcp_host_s host = 4'hF;
   logic [7:0] hd = 0, pd, od, alo, ahi, len;
   logic [7:0] prog [17];
   logic [7:0] rbyte = 0;
   logic [15:0] addr;
   logic oe_n, rd_n, wr_n, iorq_n, mreq_n, ctl_n, brq, brq_oe_n, en;
   int fails = 0, cmp_count = 0, cyc = 0, nwr = 0, nrd = 0;
   always #5 clk = ~clk;
   wire busreq_n = brq_oe_n ? 1'b1 : 1'b0;
   dcp_core u_dut (.i_mclk(clk), .i_sys_rst(rst), .i_host(host),
      .i_data(ctl_n ? hd : pd), .i_rdy(rdy), .i_bai_n(bai_n), .i_busreq_n(busreq_n),
      .o_data(od), .o_data_oe_n(oe_n), .o_addr(addr), .o_rd_n(rd_n), .o_wr_n(wr_n),
      .o_iorq_n(iorq_n), .o_mreq_n(mreq_n), .o_ctl_oe_n(ctl_n), .o_busreq_n(brq),
      .o_busreq_oe_n(brq_oe_n), .o_enabled(en));
   dcp_bus_partner u_part (.i_mclk(clk), .i_busreq_n(busreq_n), .o_bai_n(bai_n),
      .o_data(pd));
   task automatic chk(string n, logic [15:0] e, logic [15:0] s);
      cmp_count++;
      if (e !== s) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // status once a block of n bytes is done: end, ready active, byte seen, match from byte two
   function automatic logic [7:0] exp_status(int n);
      return 8'((1 << DCP_ST_EOB) | (1 << DCP_ST_RDY) | (1 << DCP_ST_XFER)
         | (int'(n > 1) << DCP_ST_MATCH));
   endfunction
   // one host byte write with a released cycle after it
   task automatic wr(logic [7:0] b);
      host = 4'b0010;
      hd = b;
      @(posedge clk) #1 host = 4'hF;
      @(posedge clk) #1;
   endtask
   // one host readback read, data one cycle after the take
   task automatic rd(string n, logic [7:0] e);
      host = 4'b0001;
      repeat (2) @(posedge clk);
      #1 chk(n, {8'h00, e}, {7'h00, oe_n, od});
      host = 4'hF;
      @(posedge clk) #1;
   endtask
   // watches device cycles mid-cycle: source walks up, destination stays fixed
   always @(negedge clk) begin
      wr_q <= wr_n;
      rd_q <= rd_n;
      if (rd_q === 1'b1 && rd_n === 1'b0 && ctl_n === 1'b0) begin
         chk("src addr", 16'({ahi, alo} + 16'(nrd)), addr);
         chk("src mreq", 0, mreq_n);
         chk("src iorq", 1, iorq_n);
         rbyte = pd;
         nrd++;
      end
      if (wr_q === 1'b1 && wr_n === 1'b0 && ctl_n === 1'b0) begin
         nwr++;
         chk("dest addr", 16'h0005, addr);
         chk("dest iorq", 0, iorq_n);
         chk("dest data", {8'h00, rbyte}, {8'h00, od});
         chk("dest oe", 0, oe_n);
      end
      if (++cyc == 20000) begin
         fails++;
         summarize();
      end
   end
   initial begin
      void'($urandom(86119));
      alo = 8'($urandom);
      ahi = 8'($urandom);
      len = 8'($urandom % 24);
      prog = '{8'h79, alo, ahi, len, 8'h00, 8'h14, 8'h28, 8'hC5, 8'h05, 8'h8A, 8'h98, 8'hFF,
         8'h00, 8'hCF, 8'h05, 8'hCF, 8'hA7};
      repeat (16) @(posedge clk);
      #1 rst = 0;
      chk("en after reset", 0, en);
      chk("busreq oe after reset", 1, brq_oe_n);
      foreach (prog[i]) begin
         wr(prog[i]);
      end
      rd("status", 8'h00);
      rd("count lo", 8'h00);
      rd("count hi", 8'h00);
      rd("a lo", alo);
      rd("a hi", ahi);
      rd("b lo", 8'h05);
      rd("b hi", 8'h00);
      wr(8'hBB);
      wr(8'h18);
      wr(8'hA7);
      rd("masked a lo", alo);
      rd("masked a hi", ahi);
      rd("wrapped a lo", alo);
      wr(8'h87);
      chk("enabled", 1, en);
      wr(8'h83);
      chk("disabled by command", 0, en);
      wr(8'h87);
      rdy = 1;
      for (int k = 0; k < 3000 && en === 1'b1; k++) @(posedge clk) #1;
      chk("enable after block", 0, en);
      chk("bytes moved", 16'(len) + 16'd1, 16'(nwr));
      chk("bytes read", 16'(len) + 16'd1, 16'(nrd));
      rd("a hi after block", 8'((16'({ahi, alo}) + 16'(len) + 16'd1) >> 8));
      wr(8'hBF);
      rd("status after block", exp_status(int'(len) + 1));
      repeat (4) @(posedge clk) #1;
      chk("bus released", 1, brq_oe_n);
      chk("busreq pin", 1, brq);
      summarize();
   end
endmodule // tb_dma_channel_programming_core

// *** verilog/dcp_core.sv ***
// dma channel programming core: host register access and transfer sequencer
// Contract
// - write strobe is host input when idle, device output once bus is owned
// - 8-bit data bus, 16-bit address bus, both port addresses share it
// - 21 writable and seven readable byte registers, counters buffered by starts
// - seven write groups: base byte plus 14 associated registers in total
// - base byte pointer bits select following bytes, stored in fixed group order
// - group recognised from identification bits; D0, D1, D7 for transfer setup
// - readback runs status through second port high, skipping masked registers
// - initiate-read or read-status command starts readback, needed after reset
// - reset puts device disabled: no bus request, no transfer
// - every command byte disables the device until an enable command
// - byte counter increments per transfer and is compared to block length
// - match compared during next byte read, flagged one byte late
// - load copies start address only into the source port counter
// - once owned the buses are kept to the end of the byte, burst or block, never preempted
// - one byte more than block length is transferred
// - transfer setup base: length, first port pointers, direction, operation
// - port base: timing follows, fixed, increment, io versus memory
// - mode base: transfer mode, interrupt byte, second port address pointers
// - control base: auto restart, wait function, ready polarity
// - CF loads source counter and clears byte count; 87 enables
module dcp_core
   import dcp_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire dcp_host_s i_host,
   input wire logic [7:0] i_data,
   input wire logic i_rdy,
   input wire logic i_bai_n,
   input wire logic i_busreq_n,
   output logic [7:0] o_data,
   output logic o_data_oe_n,
   output logic [15:0] o_addr,
   output logic o_rd_n,
   output logic o_wr_n,
   output logic o_iorq_n,
   output logic o_mreq_n,
   output logic o_ctl_oe_n,
   output logic o_busreq_n,
   output logic o_busreq_oe_n,
   output logic o_enabled
);
   dcp_state_s s_q;
   dcp_state_s s_d;
   logic host_wr;
   logic host_rd;
   logic hw_edge;
   logic hr_edge;
   logic rdy_act;
   logic is_base;
   logic is_cmd;
   logic [2:0] ptr_k;
   logic [7:0] rd_val;
   logic finish;
   logic end_blk;
   logic cmp_eq;
   logic [15:0] src_cnt;
   logic [15:0] dst_cnt;
   dcp_port_s src_port;
   dcp_port_s dst_port;

   // next unmasked readback index at or after a start index, wrapping
   function automatic logic [2:0] next_rd(input logic [6:0] m, input logic [2:0] from);
      logic [2:0] r;
      int idx;
      r = from;
      for (int i = DCP_RR_NUM - 1; i >= 0; i--) begin
         idx = (int'(from) + i) % DCP_RR_NUM;
         if (m[idx]) begin
            r = 3'(idx);
         end
      end
      return r;
   endfunction

   // lowest pending pointer of the current group
   function automatic logic [2:0] lowest(input logic [4:0] m);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 4; i >= 0; i--) begin
         if (m[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

   // address counter step: fixed, increment or decrement
   function automatic logic [15:0] step(input logic [15:0] c, input dcp_port_s p);
      logic [15:0] r;
      r = c;
      if (!p.fixed) begin
         r = p.inc ? 16'(c + 16'h0001) : 16'(c - 16'h0001);
      end
      return r;
   endfunction

   // host strobes count only while the buses are not owned
   assign host_wr = !i_host.ce_n && !i_host.iorq_n && !i_host.wr_n && s_q.bus_oe_n;
   assign host_rd = !i_host.ce_n && !i_host.iorq_n && !i_host.rd_n && s_q.bus_oe_n;
   assign hw_edge = host_wr && !s_q.hw_prev;
   assign hr_edge = host_rd && !s_q.hr_prev;
   assign rdy_act = s_q.rdy_high ? i_rdy : !i_rdy;
   assign is_base = (s_q.ptr_mask == 5'h00);
   assign is_cmd = is_base && i_data[7] && (i_data[1:0] == 2'h3);
   assign ptr_k = lowest(s_q.ptr_mask);
   assign src_cnt = s_q.dir_a2b ? s_q.a_cnt : s_q.b_cnt;
   assign dst_cnt = s_q.dir_a2b ? s_q.b_cnt : s_q.a_cnt;
   assign src_port = s_q.dir_a2b ? s_q.a_port : s_q.b_port;
   assign dst_port = s_q.dir_a2b ? s_q.b_port : s_q.a_port;
   // masked compare of the previous byte against the match byte
   assign cmp_eq = ((s_q.prev_byte ^ s_q.match_byte) & ~s_q.cmp_mask) == 8'h00;
   assign finish = ((s_q.phase == PH_READ && !s_q.xfer_op[0]) || s_q.phase == PH_WRITE)
                   && !(s_q.wait_en && !i_host.ce_n);
   assign end_blk = (s_q.byte_cnt == s_q.blk_len);

   // readback multiplexer
   always_comb begin
      unique case (s_q.rd_ptr)
         3'h0: rd_val = {2'h0, s_q.eob, s_q.match_hit, 2'h0, rdy_act, s_q.xfer_seen};
         3'h1: rd_val = s_q.byte_cnt[7:0];
         3'h2: rd_val = s_q.byte_cnt[15:8];
         3'h3: rd_val = s_q.a_cnt[7:0];
         3'h4: rd_val = s_q.a_cnt[15:8];
         3'h5: rd_val = s_q.b_cnt[7:0];
         3'h6: rd_val = s_q.b_cnt[15:8];
         default: rd_val = 8'h00;
      endcase
   end

   // next state
   always_comb begin
      logic stop;
      stop = 1'b0;
      s_d = s_q;
      s_d.hw_prev = host_wr;
      s_d.hr_prev = host_rd;
      // host readback, one register per read strobe
      if (hr_edge && s_q.rd_valid) begin
         s_d.data = rd_val;
         s_d.data_oe_n = 1'b0;
         s_d.rd_ptr = next_rd(s_q.rd_mask, (s_q.rd_ptr == 3'h6) ? 3'h0 : 3'(s_q.rd_ptr + 3'h1));
      end else if (!host_rd && s_q.bus_oe_n) begin
         s_d.data_oe_n = 1'b1;
      end
      // host writes: associated byte or new base byte
      if (hw_edge && !is_base) begin
         s_d.ptr_mask[ptr_k] = 1'b0;
         unique case (s_q.group)
            GRP_XFER: begin
               unique case (ptr_k)
                  3'h0: s_d.a_start[7:0] = i_data;
                  3'h1: s_d.a_start[15:8] = i_data;
                  3'h2: s_d.blk_len[7:0] = i_data;
                  default: s_d.blk_len[15:8] = i_data;
               endcase
            end
            GRP_MATCH: begin
               if (ptr_k == 3'h0) begin
                  s_d.cmp_mask = i_data;
               end else begin
                  s_d.match_byte = i_data;
               end
            end
            GRP_MODE: begin
               unique case (ptr_k)
                  3'h0: s_d.b_start[7:0] = i_data;
                  3'h1: s_d.b_start[15:8] = i_data;
                  3'h2: begin
                     // interrupt control byte chains pulse and vector bytes
                     s_d.ptr_mask[3] = i_data[DCP_B_PULSE];
                     s_d.ptr_mask[4] = i_data[DCP_B_VEC];
                  end
                  default: s_d.ptr_mask[ptr_k] = 1'b0;
               endcase
            end
            GRP_CMD: s_d.rd_mask = i_data[6:0];
            default: s_d.ptr_mask[ptr_k] = 1'b0; // timing bytes are consumed
         endcase
      end else if (hw_edge) begin
         if (!i_data[7] && i_data[1:0] != 2'h0) begin
            s_d.group = GRP_XFER;
            s_d.xfer_op = i_data[1:0];
            s_d.dir_a2b = i_data[DCP_B_DIR];
            s_d.ptr_mask = {1'b0, i_data[6:3]};
         end else if (!i_data[7]) begin
            s_d.group = i_data[2] ? GRP_PORT1 : GRP_PORT2;
            s_d.ptr_mask = {4'h0, i_data[DCP_B_TIM]};
            if (i_data[2]) begin
               s_d.a_port = '{i_data[DCP_B_FIXED], i_data[DCP_B_INC], i_data[DCP_B_IO]};
            end else begin
               s_d.b_port = '{i_data[DCP_B_FIXED], i_data[DCP_B_INC], i_data[DCP_B_IO]};
            end
         end else begin
            unique case (i_data[1:0])
               2'h0: begin
                  s_d.group = GRP_MATCH;
                  s_d.stop_on_match = i_data[DCP_B_STOP];
                  s_d.ptr_mask = {3'h0, i_data[4:3]};
               end
               2'h1: begin
                  s_d.group = GRP_MODE;
                  s_d.mode = i_data[6:5];
                  s_d.ptr_mask = {2'h0, i_data[4:2]};
               end
               2'h2: begin
                  s_d.group = GRP_CTRL;
                  s_d.auto_restart = i_data[DCP_B_AUTO];
                  s_d.wait_en = i_data[DCP_B_WAIT];
                  s_d.rdy_high = i_data[DCP_B_RDYH];
                  s_d.ptr_mask = 5'h00;
               end
               default: begin
                  s_d.group = GRP_CMD;
                  s_d.enabled = 1'b0;
                  unique case (i_data)
                     DCP_CMD_ENABLE: s_d.enabled = 1'b1;
                     DCP_CMD_LOAD: begin
                        // only the source counter is loaded
                        if (s_q.dir_a2b) begin
                           s_d.a_cnt = s_q.a_start;
                        end else begin
                           s_d.b_cnt = s_q.b_start;
                        end
                        s_d.byte_cnt = DCP_WORD_RST;
                        s_d.prev_valid = 1'b0;
                        s_d.match_hit = 1'b0;
                        s_d.eob = 1'b0;
                        s_d.xfer_seen = 1'b0;
                     end
                     DCP_CMD_RD_MASK: s_d.ptr_mask = 5'h01;
                     DCP_CMD_INIT_RD: begin
                        s_d.rd_valid = 1'b1;
                        s_d.rd_ptr = next_rd(s_q.rd_mask, 3'h0);
                     end
                     DCP_CMD_RD_STAT: begin
                        s_d.rd_valid = 1'b1;
                        s_d.rd_ptr = 3'h0;
                     end
                     DCP_CMD_RESET: begin
                        s_d.match_hit = 1'b0;
                        s_d.eob = 1'b0;
                        s_d.rd_valid = 1'b0;
                     end
                     default: s_d.group = GRP_CMD;
                  endcase
               end
            endcase
         end
      end
      // transfer sequencer
      unique case (s_q.phase)
         PH_IDLE: begin
            if (s_q.enabled && rdy_act && i_busreq_n && !s_q.eob && !hw_edge) begin
               s_d.phase = PH_REQ;
               s_d.busreq_oe_n = 1'b0;
               s_d.bai_hist = 2'h0;
            end
         end
         PH_REQ: begin
            s_d.bai_hist = {s_q.bai_hist[0], !i_bai_n};
            if (!s_q.enabled) begin
               s_d.phase = PH_IDLE;
               s_d.busreq_oe_n = 1'b1;
            end else if (s_q.bai_hist[0] && !i_bai_n) begin
               s_d.phase = PH_READ;
            end
         end
         PH_HOLD: begin
            // continuous mode idles on the bus awaiting ready
            if (rdy_act) begin
               s_d.phase = PH_READ;
            end
         end
         PH_READ: begin
            if (!(s_q.wait_en && !i_host.ce_n)) begin
               s_d.held_byte = i_data;
               s_d.prev_byte = i_data;
               s_d.prev_valid = 1'b1;
               if (s_q.prev_valid && cmp_eq) begin
                  s_d.match_hit = 1'b1;
               end
               if (s_q.xfer_op[0]) begin
                  s_d.phase = PH_WRITE;
               end
            end
         end
         default: begin
            s_d.phase = PH_WRITE;
         end
      endcase
      // end of one byte operation
      if (finish) begin
         s_d.xfer_seen = 1'b1;
         s_d.byte_cnt = 16'(s_q.byte_cnt + 16'h0001);
         if (s_q.dir_a2b) begin
            s_d.a_cnt = step(s_q.a_cnt, s_q.a_port);
            s_d.b_cnt = step(s_q.b_cnt, s_q.b_port);
         end else begin
            s_d.a_cnt = step(s_q.a_cnt, s_q.a_port);
            s_d.b_cnt = step(s_q.b_cnt, s_q.b_port);
         end
         if (!s_q.xfer_op[0]) begin
            s_d.b_cnt = s_q.dir_a2b ? s_q.b_cnt : s_d.b_cnt;
            s_d.a_cnt = s_q.dir_a2b ? s_d.a_cnt : s_q.a_cnt;
         end
         stop = s_q.stop_on_match && s_q.xfer_op[1] && s_d.match_hit;
         if (end_blk && s_q.auto_restart && !stop) begin
            s_d.a_cnt = s_q.a_start;
            s_d.b_cnt = s_q.b_start;
            s_d.byte_cnt = DCP_WORD_RST;
         end else if (end_blk) begin
            s_d.eob = 1'b1;
            stop = 1'b1;
         end
         if (stop || s_q.mode == DCP_MODE_BYTE || (s_q.mode == DCP_MODE_BURST && !rdy_act)) begin
            s_d.phase = PH_IDLE;
            s_d.busreq_oe_n = 1'b1;
            s_d.enabled = s_q.enabled && !stop;
         end else begin
            s_d.phase = rdy_act ? PH_READ : PH_HOLD;
         end
      end
      // pin drive for the coming phase
      s_d.bus_oe_n = !(s_d.phase == PH_READ || s_d.phase == PH_WRITE || s_d.phase == PH_HOLD);
      s_d.rd_n = !(s_d.phase == PH_READ);
      s_d.wr_n = !(s_d.phase == PH_WRITE);
      s_d.iorq_n = 1'b1;
      s_d.mreq_n = 1'b1;
      if (s_d.phase == PH_READ) begin
         s_d.addr = (s_d.phase == s_q.phase) ? s_q.addr : (finish ? s_d.a_cnt : src_cnt);
         s_d.iorq_n = !src_port.io;
         s_d.mreq_n = src_port.io;
      end else if (s_d.phase == PH_WRITE) begin
         s_d.addr = dst_cnt;
         s_d.iorq_n = !dst_port.io;
         s_d.mreq_n = dst_port.io;
         s_d.data = (s_q.phase == PH_READ) ? i_data : s_q.data;
         s_d.data_oe_n = 1'b0;
      end else if (s_q.phase == PH_WRITE) begin
         s_d.data_oe_n = 1'b1;
      end
      if (s_d.phase == PH_READ && finish) begin
         s_d.addr = s_q.dir_a2b ? s_d.a_cnt : s_d.b_cnt;
      end
   end

   // state register
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         s_q <= DCP_STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs come straight from the state register
   assign o_data = s_q.data;
   assign o_data_oe_n = s_q.data_oe_n;
   assign o_addr = s_q.addr;
   assign o_rd_n = s_q.rd_n;
   assign o_wr_n = s_q.wr_n;
   assign o_iorq_n = s_q.iorq_n;
   assign o_mreq_n = s_q.mreq_n;
   assign o_ctl_oe_n = s_q.bus_oe_n;
   assign o_busreq_n = s_q.busreq_oe_n;
   assign o_busreq_oe_n = s_q.busreq_oe_n;
   assign o_enabled = s_q.enabled;

   // checks
   property p_rst_disabled;
      @(posedge i_mclk) i_sys_rst |=> !o_enabled && o_busreq_oe_n && o_ctl_oe_n;
   endproperty
   a_rst_disabled: assert property (p_rst_disabled) else $error("not disabled after reset");

   property p_no_req_disabled;
      @(posedge i_mclk) disable iff (i_sys_rst)
         (s_q.phase == PH_IDLE && !s_q.enabled) |=> o_busreq_oe_n;
   endproperty
   a_no_req_disabled: assert property (p_no_req_disabled) else $error("request while disabled");

   property p_cmd_disables;
      @(posedge i_mclk) disable iff (i_sys_rst)
         (hw_edge && is_cmd && i_data != DCP_CMD_ENABLE) |=> !o_enabled;
   endproperty
   a_cmd_disables: assert property (p_cmd_disables) else $error("command left device enabled");

   property p_enable;
      @(posedge i_mclk) disable iff (i_sys_rst)
         (hw_edge && is_cmd && i_data == DCP_CMD_ENABLE) |=> o_enabled ##1 o_enabled;
   endproperty
   a_enable: assert property (p_enable) else $error("enable command ignored");

   property p_count;
      @(posedge i_mclk) disable iff (i_sys_rst)
         (finish && !end_blk) |=> s_q.byte_cnt == 16'($past(s_q.byte_cnt) + 16'h0001);
   endproperty
   a_count: assert property (p_count) else $error("byte counter did not advance");

   property p_eob;
      @(posedge i_mclk) disable iff (i_sys_rst)
         (finish && end_blk && !s_q.auto_restart) |=> s_q.eob && o_busreq_oe_n;
   endproperty
   a_eob: assert property (p_eob) else $error("end of block missed");

   property p_match_late;
      @(posedge i_mclk) disable iff (i_sys_rst)
         (s_q.phase == PH_READ && !(s_q.wait_en && !i_host.ce_n) && s_q.prev_valid && cmp_eq)
         |=> s_q.match_hit;
   endproperty
   a_match_late: assert property (p_match_late) else $error("pipelined match lost");

   property p_load_src;
      @(posedge i_mclk) disable iff (i_sys_rst)
         (hw_edge && is_cmd && i_data == DCP_CMD_LOAD && s_q.phase == PH_IDLE)
         |=> (s_q.dir_a2b ? (s_q.a_cnt == $past(s_q.a_start) && s_q.b_cnt == $past(s_q.b_cnt))
                          : (s_q.b_cnt == $past(s_q.b_start) && s_q.a_cnt == $past(s_q.a_cnt)))
             && s_q.byte_cnt == DCP_WORD_RST;
   endproperty
   a_load_src: assert property (p_load_src) else $error("load touched wrong counter");

   property p_keep_bus;
      @(posedge i_mclk) disable iff (i_sys_rst)
         (s_q.phase == PH_READ && !finish && !i_busreq_n) |-> !o_busreq_oe_n ##1 !o_busreq_oe_n;
   endproperty
   a_keep_bus: assert property (p_keep_bus) else $error("bus released mid byte");

   property p_readback;
      @(posedge i_mclk) disable iff (i_sys_rst)
         (hr_edge && s_q.rd_valid) |=> o_data == $past(rd_val) && !o_data_oe_n;
   endproperty
   a_readback: assert property (p_readback) else $error("wrong readback byte");

   c_enable: cover property (@(posedge i_mclk) hw_edge && is_cmd && i_data == DCP_CMD_ENABLE);
   c_eob: cover property (@(posedge i_mclk) finish && end_blk);
   c_match: cover property (@(posedge i_mclk) !s_q.match_hit ##1 s_q.match_hit);
   c_read: cover property (@(posedge i_mclk) hr_edge && s_q.rd_valid);
endmodule // dcp_core
